// ==== src/qt_pkg.sv ====
// Package: register map, mode codes and reset values of the quad PWM timer
package qt_pkg;

  // ----------------------------------------------------------------
  // Register offsets (byte addresses on the 16-bit register port)
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_MODE = 8'h80;
  localparam logic [7:0] OFS_IO1 = 8'h82;
  localparam logic [7:0] OFS_IO2 = 8'h84;
  localparam logic [7:0] OFS_INTEN = 8'h86;
  localparam logic [7:0] OFS_INTPND = 8'h88;
  localparam logic [7:0] OFS_PS1 = 8'h8A;
  localparam logic [7:0] OFS_PS2 = 8'h98;
  localparam logic [7:0] OFS_CNT [4] = '{8'h8C, 8'h92, 8'h9A, 8'hA0};
  localparam logic [7:0] OFS_PER [4] = '{8'h8E, 8'h94, 8'h9C, 8'hA2};
  localparam logic [7:0] OFS_DTY [4] = '{8'h90, 8'h96, 8'h9E, 8'hA4};

  // ----------------------------------------------------------------
  // Field layout and codes
  // ----------------------------------------------------------------
  // Mode register: nibble per subsystem, run low, run high, 2-bit mode
  localparam int MODE_NIB = 4;
  localparam int MODE_RUN0 = 0;
  localparam int MODE_RUN1 = 1;
  localparam int MODE_OP = 2;
  // Pin control: nibble per pin, default polarity bit in the nibble
  localparam int PIN_NIB = 4;
  localparam int PIN_POL = 0;
  localparam logic [1:0] OP_LOW = 2'h0;
  localparam logic [1:0] OP_DUAL8 = 2'h1;
  localparam logic [1:0] OP_PWM16 = 2'h2;
  localparam logic [1:0] OP_CAPT = 2'h3;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [15:0] RST_REG = 16'h0000;
  localparam logic [7:0] RST_PSC = 8'h00;

endpackage : qt_pkg

// ==== src/qt_timer.sv ====
// Quad timer: four subsystems with dual 8-bit PWM, 16-bit PWM and capture
// Summary of operation
// (RULE1) Four independent subsystems: 8-bit prescaler, 16-bit counter, two 16-bit compares.
// (RULE2) Modes per subsystem: low power, dual 8-bit PWM, 16-bit PWM, capture.
// (RULE3) Sixteen pending flags with enables; four per subsystem merge into one request.
// (RULE4) Each pin is a PWM output with polarity or a capture input.
// (RULE5) Dual 8-bit mode splits the counter into two byte counters, one per pin.
// (RULE6) Each byte counter has its own run bit; prescaler runs if either runs.
// (RULE7) Counter steps when prescaler count equals divisor: divide by divisor plus one.
// (RULE8) PWM period is (period+1) times (divisor+1) clock periods.
// (RULE9) Pin starts at default level; counter clears on the step after period match.
// (RULE10) Step from 00h to 01h drives the pin to the non-default level.
// (RULE11) Duty match returns the pin to default on the next step.
// (RULE12) Duty above period holds the pin non-default: 100 percent. In 16-bit mode a period of zero keeps the pin at default.
// (RULE13) Duty of zero holds the pin at default: 0 percent.
// (RULE14) Period and duty writes while running wait for old period match or stop.
// (RULE15) Reading period or duty returns the last written value.
// (RULE16) Counter writes are taken only while both run bits are clear.
// (RULE17) A preset counter counts up from it; pin stays default until 00h to 01h.
// (RULE18) Preset above period counts to FFh, rolls to 00h, then runs normally.
// (RULE19) Clearing a run bit sets default level, freezes counter, applies buffered values.
// (RULE20) Prescaler stops and clears only when both run bits are clear.
// (RULE21) Mode code 00 is low power: all subsystem clocks stop whatever the run bits.
// (RULE22) Dual 8-bit flags: low duty, low period, high duty, high period match.
// (RULE23) Subsystem request is high while an enabled pending flag is set.
//
// Strobed register access and the address map were chosen for this implementation.
`timescale 1ns/1ps
module qt_timer
  import qt_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Register port
  input wire logic [7:0] addr,
  input wire logic [15:0] wdata,
  input wire logic wr_stb,
  input wire logic rd_stb,
  output logic [15:0] rdata,
  // Timer pins, two per subsystem
  input wire logic [7:0] timer_io_pin_in,
  output logic [7:0] timer_io_pin_out,
  output logic [7:0] timer_io_pin_oe,
  // One request per subsystem
  output logic [3:0] irq
);

  // ----------------------------------------------------------------
  // Shared registers and per-subsystem state
  // ----------------------------------------------------------------
  logic [15:0] subsystem_op_mode;
  logic [15:0] pin_control [2];
  logic [15:0] int_enable;
  logic [15:0] pending;
  logic [15:0] prescale_divisor [2];
  logic [15:0] subsystem_counter [4];
  logic [15:0] period_value [4];
  logic [15:0] duty_value [4];
  logic [15:0] period_act [4];
  logic [15:0] duty_act [4];
  logic [7:0] psc [4];
  logic [1:0] out_q [4];
  logic [1:0] oe_q [4];
  logic [3:0] pnd_set [4];
  logic [3:0] clr_ok [4];
  logic [7:0] pin_s1;
  logic [7:0] pin_s2;
  logic [7:0] pin_s3;
  logic [7:0] rise;
  logic [15:0] next_rdata;

  // Pin inputs cross into the clock domain through two flops
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      pin_s1 <= 8'h00;
      pin_s2 <= 8'h00;
      pin_s3 <= 8'h00;
    end
    else
    begin
      pin_s1 <= timer_io_pin_in;
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
    end
  end

  // Rising edges only; the first flop stays private to the synchroniser
  assign rise = pin_s2 & ~pin_s3;

  // ----------------------------------------------------------------
  // Software control registers
  // ----------------------------------------------------------------
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      subsystem_op_mode <= RST_REG;
      pin_control[0] <= RST_REG;
      pin_control[1] <= RST_REG;
      int_enable <= RST_REG;
      prescale_divisor[0] <= RST_REG;
      prescale_divisor[1] <= RST_REG;
    end
    else if (wr_stb)
    begin
      case (addr)
        OFS_MODE: subsystem_op_mode <= wdata;
        OFS_IO1: pin_control[0] <= wdata;
        OFS_IO2: pin_control[1] <= wdata;
        OFS_INTEN: int_enable <= wdata;
        OFS_PS1: prescale_divisor[0] <= wdata;
        OFS_PS2: prescale_divisor[1] <= wdata;
        default: ;
      endcase
    end
  end

  // Pending flags: a hardware event in the clearing cycle survives
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      pending <= RST_REG;
    else
    begin
      for (int s = 0; s < 4; s++)
      begin
        if (wr_stb && addr == OFS_INTPND)
          pending[4*s +: 4] <= (pending[4*s +: 4] & ~(wdata[4*s +: 4] & clr_ok[s]))
            | pnd_set[s];  // see (RULE3)
        else
          pending[4*s +: 4] <= pending[4*s +: 4] | pnd_set[s];
      end
    end
  end

  // One request per subsystem from its four enabled flags
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      irq <= 4'h0;
    else
    begin
      for (int s = 0; s < 4; s++)
        irq[s] <= |(pending[4*s +: 4] & int_enable[4*s +: 4]);  // see (RULE23)
    end
  end

  // ----------------------------------------------------------------
  // Timer subsystems
  // ----------------------------------------------------------------
  for (genvar i = 0; i < 4; i++)  // see (RULE1)
  begin : g_sub
    logic [1:0] op;
    logic run0;
    logic run1;
    logic psc_on;
    logic tick;
    logic pwm;
    logic [7:0] div;
    logic [1:0] pol;
    logic [1:0] act_q;
    logic [1:0] next_act;
    logic [15:0] next_cnt;
    logic [3:0] ev;
    logic upd;
    logic per_hit;
    logic cnt_wr;
    logic per_wr;
    logic dty_wr;
    logic [1:0] run_q;
    logic stop_ev;

    assign op = subsystem_op_mode[MODE_NIB*i+MODE_OP +: 2];
    assign run0 = subsystem_op_mode[MODE_NIB*i+MODE_RUN0];
    assign run1 = subsystem_op_mode[MODE_NIB*i+MODE_RUN1];
    assign div = prescale_divisor[i/2][8*(i%2) +: 8];
    assign pol[0] = pin_control[i/2][PIN_NIB*(2*(i%2))+PIN_POL];
    assign pol[1] = pin_control[i/2][PIN_NIB*(2*(i%2)+1)+PIN_POL];
    assign pwm = (op == OP_DUAL8) || (op == OP_PWM16);
    // Either byte channel starts the shared prescaler in dual mode
    assign psc_on = (op == OP_DUAL8) ? (run0 | run1)
      : ((op != OP_LOW) && run0);  // see (RULE6) (RULE21)
    assign tick = psc_on && (psc[i] == div);  // see (RULE7) (RULE8)
    // Low power keeps flags from being cleared
    assign clr_ok[i] = (op == OP_LOW) ? 4'h0 : 4'hF;
    assign pnd_set[i] = ev;
    assign cnt_wr = wr_stb && addr == OFS_CNT[i] && op != OP_LOW && !run0 && !run1;
    assign per_wr = wr_stb && addr == OFS_PER[i] && op != OP_LOW;
    assign dty_wr = wr_stb && addr == OFS_DTY[i] && op != OP_LOW;
    assign per_hit = (op == OP_DUAL8) ? (ev[1] | ev[3]) : ev[1];
    // A channel that stops completes a buffered update even while its twin runs
    assign stop_ev = (op == OP_DUAL8) ? |(run_q & ~{run1, run0}) : (run_q[0] && !run0);  // see (RULE19)

    // Prescaler: frozen in low power, cleared once nothing runs
    always_ff @(posedge clock or posedge rst)
    begin
      if (rst)
        psc[i] <= RST_PSC;
      else if (op == OP_LOW)
        psc[i] <= psc[i];  // see (RULE21)
      else if (!psc_on)
        psc[i] <= RST_PSC;  // see (RULE20)
      else if (tick)
        psc[i] <= RST_PSC;
      else
        psc[i] <= psc[i] + 8'h01;
    end

    // Counter step, pin level and events for the current mode
    always_comb
    begin
      logic [7:0] b;
      logic [7:0] pb;
      logic [7:0] db;
      logic run_c;
      b = 8'h00;
      pb = 8'h00;
      db = 8'h00;
      run_c = 1'b0;
      next_cnt = subsystem_counter[i];
      next_act = act_q;
      ev = 4'h0;
      case (op)  // see (RULE2)
        OP_DUAL8:
        begin
          for (int c = 0; c < 2; c++)
          begin
            b = subsystem_counter[i][8*c +: 8];  // see (RULE5)
            pb = period_act[i][8*c +: 8];
            db = duty_act[i][8*c +: 8];
            run_c = (c == 0) ? run0 : run1;
            if (!run_c)
              next_act[c] = 1'b0;  // see (RULE19)
            else if (tick)
            begin
              // Duty match first, so a zero duty never leaves default
              if (b == db)
              begin
                next_act[c] = 1'b0;  // see (RULE11) (RULE13)
                ev[2*c] = 1'b1;  // see (RULE22)
              end
              else if (b == 8'h00)
                next_act[c] = 1'b1;  // see (RULE10) (RULE12) (RULE17)
              if (b == pb)
              begin
                next_cnt[8*c +: 8] = 8'h00;  // see (RULE9)
                ev[2*c+1] = 1'b1;
              end
              else
                next_cnt[8*c +: 8] = b + 8'h01;  // see (RULE18)
            end
          end
        end
        OP_PWM16:
        begin
          if (!run0)
            next_act = 2'b00;
          else if (tick)
          begin
            if (subsystem_counter[i] == duty_act[i])
            begin
              next_act = 2'b00;
              ev[0] = 1'b1;
            end
            else if (subsystem_counter[i] == 16'h0000 && period_act[i] != 16'h0000)
              next_act = 2'b11;
            if (subsystem_counter[i] == period_act[i])
            begin
              next_cnt = 16'h0000;
              ev[1] = 1'b1;
            end
            else
              next_cnt = subsystem_counter[i] + 16'h0001;
          end
        end
        OP_CAPT:
        begin
          next_act = 2'b00;
          if (tick)
          begin
            next_cnt = subsystem_counter[i] + 16'h0001;
            ev[2] = (subsystem_counter[i] == 16'hFFFF);
          end
          ev[0] = run0 && rise[2*i];
          ev[1] = run0 && rise[2*i+1];
        end
        default: ;
      endcase
    end

    // Counter: software preset only while both channels are stopped
    always_ff @(posedge clock or posedge rst)
    begin
      if (rst)
        subsystem_counter[i] <= RST_REG;
      else if (cnt_wr)
        subsystem_counter[i] <= wdata;  // see (RULE16) (RULE17)
      else
        subsystem_counter[i] <= next_cnt;
    end

    // Compare values: the visible copy plus the copy the comparators use
    always_ff @(posedge clock or posedge rst)
    begin
      if (rst)
      begin
        period_value[i] <= RST_REG;
        duty_value[i] <= RST_REG;
        period_act[i] <= RST_REG;
        duty_act[i] <= RST_REG;
        upd <= 1'b0;
      end
      else
      begin
        if (op == OP_CAPT && ev[0])
        begin
          period_value[i] <= subsystem_counter[i];
          period_act[i] <= subsystem_counter[i];
        end
        if (op == OP_CAPT && ev[1])
        begin
          duty_value[i] <= subsystem_counter[i];
          duty_act[i] <= subsystem_counter[i];
        end
        // Buffered values land at the old period match or on stop
        if (upd && (per_hit || !psc_on || stop_ev))
        begin
          period_act[i] <= period_value[i];  // see (RULE14) (RULE19)
          duty_act[i] <= duty_value[i];
          upd <= 1'b0;
        end
        if (per_wr)
        begin
          period_value[i] <= wdata;  // see (RULE15)
          if (pwm && psc_on)
            upd <= 1'b1;  // see (RULE14)
          else
            period_act[i] <= wdata;
        end
        if (dty_wr)
        begin
          duty_value[i] <= wdata;  // see (RULE15)
          if (pwm && psc_on)
            upd <= 1'b1;
          else
            duty_act[i] <= wdata;
        end
      end
    end

    // Pin drivers come straight from flops; capture mode releases them
    always_ff @(posedge clock or posedge rst)
    begin
      if (rst)
      begin
        act_q <= 2'b00;
        run_q <= 2'b00;
        out_q[i] <= 2'b00;
        oe_q[i] <= 2'b00;
      end
      else
      begin
        act_q <= next_act;
        run_q <= {run1, run0};  // Last run bits, to see a channel stop
        out_q[i] <= pol ^ next_act;  // see (RULE4) (RULE9)
        oe_q[i] <= pwm ? 2'b11 : 2'b00;
      end
    end
  end

  assign timer_io_pin_out = {out_q[3], out_q[2], out_q[1], out_q[0]};
  assign timer_io_pin_oe = {oe_q[3], oe_q[2], oe_q[1], oe_q[0]};

  // ----------------------------------------------------------------
  // Read port
  // ----------------------------------------------------------------
  // Read value decode; unmapped addresses read zero
  always_comb
  begin
    next_rdata = 16'h0000;
    case (addr)
      OFS_MODE: next_rdata = subsystem_op_mode;
      OFS_IO1: next_rdata = pin_control[0];
      OFS_IO2: next_rdata = pin_control[1];
      OFS_INTEN: next_rdata = int_enable;
      OFS_INTPND: next_rdata = pending;
      OFS_PS1: next_rdata = prescale_divisor[0];
      OFS_PS2: next_rdata = prescale_divisor[1];
      default: ;
    endcase
    for (int s = 0; s < 4; s++)
    begin
      if (addr == OFS_CNT[s])
        next_rdata = subsystem_counter[s];
      if (addr == OFS_PER[s])
        next_rdata = period_value[s];
      if (addr == OFS_DTY[s])
        next_rdata = duty_value[s];
    end
  end

  // Read data stand for one cycle only, zero otherwise
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      rdata <= 16'h0000;
    else if (rd_stb)
      rdata <= next_rdata;
    else
      rdata <= 16'h0000;
  end

endmodule : qt_timer

// ==== verification/qt_timer_sva.sv ====
// Checker: port-level timing relations of the quad timer, subsystem 0
`timescale 1ns/1ps
module qt_timer_chk
  import qt_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Register port
  input wire logic [7:0] addr,
  input wire logic [15:0] wdata,
  input wire logic wr_stb,
  input wire logic rd_stb,
  input wire logic [15:0] rdata,
  // Pins and requests
  input wire logic [7:0] timer_io_pin_in,
  input wire logic [7:0] timer_io_pin_out,
  input wire logic [7:0] timer_io_pin_oe,
  input wire logic [3:0] irq
);
  // ----------------------------------------------------------------
  // Shadow state
  // ----------------------------------------------------------------
  logic [15:0] m;
  logic [15:0] per0;
  logic [15:0] dty0;
  logic [3:0] en;
  logic pol0;
  logic [7:0] div0;
  logic [9:0] quiet;
  logic [15:0] hi_len;
  logic [15:0] per_len;
  logic was_act;
  logic act;
  logic duty_mid;
  logic out0;
  default clocking @(posedge clock);
  endclocking
  default disable iff (rst);
  assign out0 = timer_io_pin_out[0];
  // Judge waveforms only long after the last write, once buffered values have landed
  assign act = quiet >= 10'h2BC && div0 == 8'h00 && m[3:2] == OP_DUAL8 && m[0];
  assign duty_mid = dty0[7:0] != 8'h00 && dty0[7:0] <= per0[7:0];
  // Settings as written; period and duty writes are refused in low power
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      m <= RST_REG;
      per0 <= RST_REG;
      dty0 <= RST_REG;
      en <= 4'h0;
      pol0 <= 1'b0;
      div0 <= RST_PSC;
    end
    else if (wr_stb)
    begin
      if (addr == OFS_MODE)
        m <= wdata;
      if (addr == OFS_IO1)
        pol0 <= wdata[PIN_POL];
      if (addr == OFS_INTEN)
        en <= wdata[3:0];
      if (addr == OFS_PS1)
        div0 <= wdata[7:0];
      if (addr == OFS_PER[0] && m[3:2] != OP_LOW)
        per0 <= wdata;
      if (addr == OFS_DTY[0] && m[3:2] != OP_LOW)
        dty0 <= wdata;
    end
  end
  // Quiet time, active phase length and spacing of active edges
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      quiet <= 10'h000;
      hi_len <= 16'h0000;
      per_len <= 16'h0000;
      was_act <= 1'b0;
    end
    else
    begin
      quiet <= wr_stb ? 10'h000 : (quiet == 10'h3FF ? quiet : quiet + 10'h001);
      hi_len <= (out0 != pol0) ? hi_len + 16'h0001 : 16'h0000;
      per_len <= (out0 != pol0 && !was_act) ? 16'h0001 : per_len + 16'h0001;
      was_act <= out0 != pol0;
    end
  end
  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  readback_a: assert property (rd_stb && addr == OFS_PER[0] |=> rdata == per0)
    else $error("period read back differs from last write");
  low_power_a: assert property (m[3:2] == OP_LOW && $stable(m[3:2]) |-> timer_io_pin_oe[1:0] == 2'h0)
    else $error("pins driven in low power");
  pwm_drive_a: assert property (m[3:2] == OP_DUAL8 && $stable(m[3:2]) |-> timer_io_pin_oe[1:0] == 2'h3)
    else $error("pins not driven in dual PWM");
  stop_level_a: assert property (m[3:0] == 4'h4 && $stable(m[3:0]) && $stable(pol0) |-> out0 == pol0)
    else $error("stopped pin not at default level");
  irq_mask_a: assert property (en == 4'h0 && $past(en) == 4'h0 |-> !irq[0])
    else $error("request raised with all sources disabled");
  zero_duty_a: assert property (act && dty0[7:0] == 8'h00 |-> out0 == pol0)
    else $error("zero duty left default level");
  full_duty_a: assert property (act && dty0[7:0] > per0[7:0] |-> out0 != pol0)
    else $error("full duty returned to default level");
  high_len_a: assert property (act && duty_mid && out0 == pol0 && hi_len != 16'h0000
    |-> hi_len == {8'h00, dty0[7:0]})
    else $error("active phase length wrong");
  period_len_a: assert property (act && duty_mid && out0 != pol0 && !was_act
    |-> per_len == {8'h00, per0[7:0]} + 16'h0001)
    else $error("waveform period wrong");
endmodule : qt_timer_chk

bind qt_timer qt_timer_chk u_qt_timer_chk (.clock, .rst, .addr, .wdata, .wr_stb, .rd_stb,
  .rdata, .timer_io_pin_in, .timer_io_pin_out, .timer_io_pin_oe, .irq);

// ==== verification/qt_load.sv ====
// Load model: the eight timer pins with their pull-downs
`timescale 1ns/1ps
module qt_load
  import qt_pkg::*;
(
  // Pin drive from the timer
  input wire logic [7:0] drive,
  input wire logic [7:0] drive_oe,
  // Resolved pin levels
  output logic [7:0] level
);
  // An undriven pin falls to its pull-down instead of keeping the last value
  assign level = drive & drive_oe;
endmodule : qt_load

// ==== verification/quad_timer_dual_8bit_pwm_tb.sv ====
// Testbench: dual 8-bit and 16-bit PWM behaviour of subsystem 0 of the quad timer
`timescale 1ns/1ps
module quad_timer_dual_8bit_pwm_tb
  import qt_pkg::*;
;
  logic clock;
  logic rst;
  logic wr_stb;
  logic rd_stb;
  logic [7:0] addr;
  logic [15:0] wdata;
  logic [15:0] rdata;
  logic [15:0] v;
  logic [15:0] w;
  logic [7:0] pin_out;
  logic [7:0] pin_oe;
  logic [7:0] level;
  logic [3:0] irq;
  int error_cnt = 0;
  int check_count = 0;
  int cyc = 0;
  int c;
  qt_timer u_qt_timer (.clock(clock), .rst(rst), .addr(addr), .wdata(wdata), .wr_stb(wr_stb),
    .rd_stb(rd_stb), .rdata(rdata), .timer_io_pin_in(level), .timer_io_pin_out(pin_out),
    .timer_io_pin_oe(pin_oe), .irq(irq));
  qt_load u_qt_load (.drive(pin_out), .drive_oe(pin_oe), .level(level));
  // ----------------------------------------------------------------
  // Clock, bus and compare tasks
  // ----------------------------------------------------------------
  initial
  begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  task automatic finish_test;
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : finish_test
  // Cuts a hang short; the whole run needs well under 6000 cycles
  always @(posedge clock)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      error_cnt++;
      finish_test;
    end
  end
  task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("MISMATCH %0t value %h expected %h", $time, got, exp);
    end
  endtask : chk16
  task automatic chk_n(input int got, input int exp);
    check_count++;
    if (got != exp)
    begin
      error_cnt++;
      $display("MISMATCH %0t count %0d expected %0d", $time, got, exp);
    end
  endtask : chk_n
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clock);
    addr <= a;
    wdata <= d;
    wr_stb <= 1'b1;
    @(posedge clock);
    wr_stb <= 1'b0;
  endtask : wr
  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    @(posedge clock);
    addr <= a;
    rd_stb <= 1'b1;
    @(posedge clock);
    rd_stb <= 1'b0;
    @(negedge clock);
    d = rdata;
  endtask : rd
  task automatic count_lvl(input int n, input logic lv, output int k);
    k = 0;
    repeat (n)
    begin
      @(negedge clock);
      if (level[0] === lv)
        k++;
    end
  endtask : count_lvl
  // Active phase and full period of pin 0, from one rising edge to the next
  task automatic measure(input int hi, input int per);
    int h;
    int p;
    h = 0;
    while (level[0] !== 1'b0)
      @(negedge clock);
    while (level[0] !== 1'b1)
      @(negedge clock);
    while (level[0] === 1'b1)
    begin
      @(negedge clock);
      h++;
    end
    p = h;
    while (level[0] === 1'b0)
    begin
      @(negedge clock);
      p++;
    end
    chk_n(h, hi);
    chk_n(p, per);
  endtask : measure
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset;
    rd(OFS_MODE, v);
    chk16(v, RST_REG);
    rd(8'h00, v);
    chk16(v, 16'h0000);
    wr(OFS_PER[0], 16'h0033);
    rd(OFS_PER[0], v);
    chk16(v, RST_REG);
    chk16({8'h00, pin_oe}, 16'h0000);
  endtask : t_reset
  task automatic t_pwm;
    wr(OFS_IO1, 16'h0000);
    wr(OFS_PS1, 16'h0000);
    wr(OFS_MODE, 16'h0004);
    wr(OFS_PER[0], 16'h0003);
    wr(OFS_DTY[0], 16'h0002);
    wr(OFS_INTEN, 16'h000F);
    wr(OFS_MODE, 16'h0005);
    repeat (800) @(negedge clock);
    measure(2, 4);
    rd(OFS_INTPND, v);
    chk16(v & 16'h0003, 16'h0003);
    chk16({12'h000, irq}, 16'h0001);
    wr(OFS_INTEN, 16'h0000);
    repeat (3) @(negedge clock);
    chk16({12'h000, irq}, 16'h0000);
  endtask : t_pwm
  // Zero duty at default polarity, then full duty with the polarity turned round
  task automatic t_edges;
    wr(OFS_MODE, 16'h0004);
    wr(OFS_DTY[0], 16'h0000);
    wr(OFS_MODE, 16'h0005);
    repeat (800) @(negedge clock);
    count_lvl(100, 1'b1, c);
    chk_n(c, 0);
    wr(OFS_MODE, 16'h0004);
    wr(OFS_IO1, 16'h0001);
    wr(OFS_DTY[0], 16'h0009);
    wr(OFS_MODE, 16'h0005);
    repeat (800) @(negedge clock);
    count_lvl(100, 1'b1, c);
    chk_n(c, 0);
    wr(OFS_MODE, 16'h0004);
    repeat (2) @(negedge clock);
    chk16({15'h0000, level[0]}, 16'h0001);
  endtask : t_edges
  task automatic t_buf;
    wr(OFS_IO1, 16'h0000);
    wr(OFS_DTY[0], 16'h0002);
    wr(OFS_PS1, 16'h0002);
    wr(OFS_MODE, 16'h0005);
    measure(6, 12);
    wr(OFS_PER[0], 16'h0007);
    rd(OFS_PER[0], v);
    chk16(v, 16'h0007);
    // Let the old period run out so the next rising edge belongs to the new one
    repeat (12) @(negedge clock);
    measure(6, 24);
  endtask : t_buf
  // Stop, preset above the period, restart, then a refused counter write
  task automatic t_preset;
    wr(OFS_MODE, 16'h0004);
    rd(OFS_CNT[0], v);
    rd(OFS_CNT[0], w);
    chk16(w, v);
    wr(OFS_CNT[0], 16'h00F0);
    rd(OFS_CNT[0], v);
    chk16(v, 16'h00F0);
    wr(OFS_INTPND, 16'h000F);
    rd(OFS_INTPND, v);
    chk16(v & 16'h000F, 16'h0000);
    wr(OFS_MODE, 16'h0005);
    count_lvl(45, 1'b1, c);
    chk_n(c, 0);
    measure(6, 24);
    wr(OFS_CNT[0], 16'h0050);
    wr(OFS_MODE, 16'h0004);
    rd(OFS_CNT[0], v);
    chk16({15'h0000, v[7:0] <= 8'h07}, 16'h0001);
  endtask : t_preset
  // Single 16-bit channel from a cleared counter, both pins driven
  task automatic t_pwm16;
    wr(OFS_MODE, 16'h0008);
    wr(OFS_CNT[0], 16'h0000);
    wr(OFS_PS1, 16'h0000);
    wr(OFS_PER[0], 16'h0003);
    wr(OFS_DTY[0], 16'h0002);
    wr(OFS_MODE, 16'h0009);
    measure(2, 4);
    chk16({14'h0000, pin_oe[1:0]}, 16'h0003);
  endtask : t_pwm16
  initial
  begin
    rst = 1'b1;
    wr_stb = 1'b0;
    rd_stb = 1'b0;
    addr = 8'h00;
    wdata = 16'h0000;
    repeat (20) @(posedge clock);
    rst <= 1'b0;
    t_reset;
    t_pwm;
    t_edges;
    t_buf;
    t_preset;
    t_pwm16;
    finish_test;
  end
endmodule : quad_timer_dual_8bit_pwm_tb
